// ### core/fault_classifier_pkg.sv
// constants for the memory-access fault classifier: register map, status bit
// positions, configuration bits and exception kinds.
// assumes 32-bit words whose documented bit 0 is the most significant bit.
package fault_classifier_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [5:0] reg_event_status = 6'h00;
  localparam logic [5:0] reg_event_mask = 6'h04;
  localparam logic [5:0] reg_hw_config = 6'h08;
  localparam logic [5:0] reg_control = 6'h0c;
  localparam logic [5:0] reg_saved_status = 6'h10;
  localparam logic [5:0] reg_data_fault = 6'h14;
  localparam logic [5:0] reg_fault_addr = 6'h18;
  localparam logic [5:0] reg_fault_kind = 6'h1c;

  localparam logic [31:0] word_zero = 32'h0000_0000;

  // ----------------------------------------------------------------
  // documented bit n of a word sits at index 31 - n
  // ----------------------------------------------------------------
  localparam int ssw_page_fault_bit = 31 - 1;
  localparam int ssw_exec_bit = 31 - 3;
  localparam int ssw_protect_bit = 31 - 4;
  localparam int dfs_ds_error_bit = 31 - 0;
  localparam int dfs_page_fault_bit = 31 - 1;
  localparam int dfs_protect_bit = 31 - 4;
  localparam int dfs_reserve_bit = 31 - 5;
  localparam int dfs_ext_ctrl_bit = 31 - 11;
  localparam int cfg_lock_a_bit = 31 - 18;
  localparam int cfg_lock_b_bit = 31 - 19;

  // control register: external control enable in bit index 0
  localparam int ctl_ext_enable_bit = 0;

  // ----------------------------------------------------------------
  // event status and mask layout
  // ----------------------------------------------------------------
  localparam int ev_width = 3;
  localparam int ev_inst_fault = 0;
  localparam int ev_data_fault = 1;
  localparam int ev_align_fault = 2;
  localparam logic [ev_width-1:0] ev_none = 3'h0;

  // reset values
  localparam logic [31:0] hw_config_reset = 32'h0000_0000;
  localparam logic control_ext_reset = 1'b0;

  // ----------------------------------------------------------------
  // exception chosen for one access
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    kind_none = 2'h0,
    kind_inst = 2'h1,
    kind_data = 2'h2,
    kind_align = 2'h3
  } fault_kind_t;

  // bus slave states
  typedef enum logic [1:0] {
    bus_idle = 2'h1,
    bus_answer = 2'h2
  } bus_state_t;

endpackage

// ### core/mmu_fault_classifier.sv
// memory-access fault classifier: turns translation, protection and access
// attributes of one fetch or data access into one exception with status bits.
// assumes the core presents at most one access per cycle as a one-cycle pulse
// with all attributes valid in that cycle; registers over avalon-mm.
//
// Operation
// [RQ1] fetch without page or block match: inst fault
// [RQ2] data without page or block match: data fault
// [RQ3] block protection violation: fault, status bit 4
// [RQ4] page protection violation: fault, status bit 4
// [RQ5] fetch from no-execute segment: inst fault bit3
// [RQ6] fetch from direct-store segment: inst fault bit3
// [RQ7] guarded fetch, translation on: inst fault bit3
// [RQ8] data translation off: only alignment faults
// [RQ9] zero-block to write-through/inhibited: alignment fault
// [RQ10] zero-block with cache locked: alignment fault
// [RQ11] reservation op to write-through: data fault bit5
// [RQ12] reservation/external op to direct-store: bit5
// [RQ13] float access to direct-store: alignment fault
// [RQ14] direct-store bus error: data fault bit0
// [RQ15] external op while disabled: data fault bit11
// [RQ16] multiple/string in little-endian: alignment fault
// [RQ17] misaligned operand, translation on: alignment fault
// [RQ18] save failing instruction address per fault
// [RQ19] one exception per access, only its bits
//
// Decided for this implementation: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ns

module mmu_fault_classifier (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // access request from fetch and load/store
  input wire logic access_valid,
  input wire logic access_is_fetch,
  input wire logic [31:0] access_inst_addr,
  // machine state
  input wire logic instruction_translation_enable,
  input wire logic data_translation_enable,
  input wire logic little_endian_mode,
  // translation outcome
  input wire logic block_hit,
  input wire logic page_found,
  input wire logic block_protect_violation,
  input wire logic page_protect_violation,
  input wire logic no_execute_bit,
  input wire logic direct_store_select,
  input wire logic block_guarded_bit,
  input wire logic page_guarded_bit,
  input wire logic write_through,
  input wire logic cache_inhibited,
  // access class
  input wire logic op_cache_zero,
  input wire logic op_reservation,
  input wire logic op_ext_control,
  input wire logic op_float,
  input wire logic op_multi_string,
  input wire logic operand_misaligned,
  input wire logic direct_store_error,
  // fault report to the exception logic
  output logic fault_valid,
  output logic instruction_storage_fault,
  output logic data_storage_fault,
  output logic alignment_fault,
  output logic [31:0] saved_status_word,
  output logic [31:0] data_fault_status,
  output logic [31:0] fault_inst_addr,
  // avalon-mm slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // software state
  // ----------------------------------------------------------------
  logic [31:0] hw_config_q;
  logic ext_enable_q;
  logic [fault_classifier_pkg::ev_width-1:0] ev_status_q;
  logic [fault_classifier_pkg::ev_width-1:0] ev_status_d;
  logic [fault_classifier_pkg::ev_width-1:0] ev_mask_q;

  wire cache_locked = hw_config_q[fault_classifier_pkg::cfg_lock_a_bit]
                    & hw_config_q[fault_classifier_pkg::cfg_lock_b_bit];

  // ----------------------------------------------------------------
  // instruction fetch classification
  // ----------------------------------------------------------------
  // real mode fetches never fault here; block entries override segments
  wire i_xlate = access_is_fetch & instruction_translation_enable;
  wire i_seg = i_xlate & ~block_hit;
  wire i_miss = i_seg & ~direct_store_select & ~page_found; // [RQ1]
  wire i_block_prot = i_xlate & block_hit & block_protect_violation; // [RQ3]
  wire i_page_prot = i_seg & ~direct_store_select & page_found
                   & page_protect_violation; // [RQ4]
  wire i_noexec = i_seg & no_execute_bit; // [RQ5]
  wire i_dstore = i_seg & direct_store_select; // [RQ6]
  wire i_guard = (i_xlate & block_hit & block_guarded_bit)
               | (i_seg & ~direct_store_select & page_found
                  & page_guarded_bit); // [RQ7]
  wire i_exec = i_noexec | i_dstore | i_guard;
  wire i_prot = i_block_prot | i_page_prot;
  wire i_any = i_miss | i_exec | i_prot;

  // ----------------------------------------------------------------
  // data access classification
  // ----------------------------------------------------------------
  wire d_acc = ~access_is_fetch;
  // every check except alignment needs data translation on
  wire d_xlate = d_acc & data_translation_enable; // [RQ8]
  wire d_seg = d_xlate & ~block_hit;
  wire d_ds = d_seg & direct_store_select;
  wire d_wt = d_xlate & write_through;

  // alignment causes; zero-block attribute and float checks need translation
  wire a_zero_attr = d_xlate & op_cache_zero
                   & (write_through | cache_inhibited); // [RQ9]
  wire a_zero_lock = d_acc & op_cache_zero & cache_locked; // [RQ10]
  wire a_float_ds = d_ds & op_float; // [RQ13]
  wire a_le_multi = d_acc & op_multi_string & little_endian_mode; // [RQ16]
  wire a_misalign = d_xlate & operand_misaligned; // [RQ17]
  wire a_any = a_zero_attr | a_zero_lock | a_float_ds | a_le_multi | a_misalign;

  // data-storage causes
  wire d_miss = d_seg & ~direct_store_select & ~page_found; // [RQ2]
  wire d_block_prot = d_xlate & block_hit & block_protect_violation; // [RQ3]
  wire d_page_prot = d_seg & ~direct_store_select & page_found
                   & page_protect_violation; // [RQ4]
  wire d_resv_wt = d_wt & op_reservation; // [RQ11]
  wire d_resv_ds = d_ds & (op_reservation | op_ext_control); // [RQ12]
  wire d_ds_err = d_ds & direct_store_error; // [RQ14]
  wire d_ext_off = d_xlate & op_ext_control & ~ext_enable_q; // [RQ15]
  wire d_any = d_miss | d_block_prot | d_page_prot | d_resv_wt | d_resv_ds
             | d_ds_err | d_ext_off;

  // ----------------------------------------------------------------
  // single exception selection
  // ----------------------------------------------------------------
  // alignment outranks data storage: the access never reaches translation
  wire sel_inst = access_valid & i_any; // [RQ19]
  wire sel_align = access_valid & a_any; // [RQ19]
  wire sel_data = access_valid & d_any & ~a_any; // [RQ19]
  wire sel_any = sel_inst | sel_align | sel_data;

  logic [31:0] ssw_bits;
  logic [31:0] dfs_bits;

  always_comb begin
    ssw_bits = fault_classifier_pkg::word_zero;
    dfs_bits = fault_classifier_pkg::word_zero;
    if (sel_inst) begin
      ssw_bits[fault_classifier_pkg::ssw_page_fault_bit] = i_miss; // [RQ1]
      ssw_bits[fault_classifier_pkg::ssw_protect_bit] = i_prot; // [RQ3] [RQ4]
      ssw_bits[fault_classifier_pkg::ssw_exec_bit] = i_exec; // [RQ5] [RQ6] [RQ7]
    end
    if (sel_data) begin
      dfs_bits[fault_classifier_pkg::dfs_page_fault_bit] = d_miss; // [RQ2]
      dfs_bits[fault_classifier_pkg::dfs_protect_bit] =
        d_block_prot | d_page_prot; // [RQ3] [RQ4]
      dfs_bits[fault_classifier_pkg::dfs_reserve_bit] =
        d_resv_wt | d_resv_ds; // [RQ11] [RQ12]
      dfs_bits[fault_classifier_pkg::dfs_ds_error_bit] = d_ds_err; // [RQ14]
      dfs_bits[fault_classifier_pkg::dfs_ext_ctrl_bit] = d_ext_off; // [RQ15]
    end
  end

  // plain vector: a conditional of enum constants is not an enum to strict tools
  wire [1:0] kind_d =
    sel_inst ? fault_classifier_pkg::kind_inst :
    sel_align ? fault_classifier_pkg::kind_align :
    sel_data ? fault_classifier_pkg::kind_data : fault_classifier_pkg::kind_none;

  // ----------------------------------------------------------------
  // fault report
  // ----------------------------------------------------------------
  logic [1:0] last_kind_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      fault_valid <= 1'b0;
      instruction_storage_fault <= 1'b0;
      data_storage_fault <= 1'b0;
      alignment_fault <= 1'b0;
    end else begin
      fault_valid <= sel_any;
      instruction_storage_fault <= sel_inst;
      data_storage_fault <= sel_data;
      alignment_fault <= sel_align;
    end
  end

  // status words and address hold until the next fault
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      saved_status_word <= fault_classifier_pkg::word_zero;
      data_fault_status <= fault_classifier_pkg::word_zero;
      fault_inst_addr <= fault_classifier_pkg::word_zero;
      last_kind_q <= fault_classifier_pkg::kind_none;
    end else if (sel_any) begin
      saved_status_word <= ssw_bits;
      data_fault_status <= dfs_bits;
      fault_inst_addr <= access_inst_addr; // [RQ18]
      last_kind_q <= kind_d;
    end
  end

  // ----------------------------------------------------------------
  // avalon-mm slave: one wait cycle, then answer
  // ----------------------------------------------------------------
  fault_classifier_pkg::bus_state_t bus_q;
  fault_classifier_pkg::bus_state_t bus_d;

  wire bus_req = avs_read | avs_write;
  wire wr_commit = avs_write & (bus_q == fault_classifier_pkg::bus_answer);
  wire [3:0] lanes = avs_byteenable;
  wire [31:0] lane_mask = {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}};

  always_comb begin
    case (bus_q)
      fault_classifier_pkg::bus_idle: begin
        bus_d = bus_req ? fault_classifier_pkg::bus_answer : fault_classifier_pkg::bus_idle;
      end
      fault_classifier_pkg::bus_answer: begin
        bus_d = fault_classifier_pkg::bus_idle;
      end
      default: begin
        bus_d = fault_classifier_pkg::bus_idle;
      end
    endcase
  end

  wire hit_status = avs_address == fault_classifier_pkg::reg_event_status;
  wire hit_mask = avs_address == fault_classifier_pkg::reg_event_mask;
  wire hit_config = avs_address == fault_classifier_pkg::reg_hw_config;
  wire hit_control = avs_address == fault_classifier_pkg::reg_control;
  wire hit_ssw = avs_address == fault_classifier_pkg::reg_saved_status;
  wire hit_dfs = avs_address == fault_classifier_pkg::reg_data_fault;
  wire hit_addr = avs_address == fault_classifier_pkg::reg_fault_addr;
  wire hit_kind = avs_address == fault_classifier_pkg::reg_fault_kind;

  wire [31:0] rd_word =
    hit_status ? {29'h0, ev_status_q} :
    hit_mask ? {29'h0, ev_mask_q} :
    hit_config ? hw_config_q :
    hit_control ? {31'h0, ext_enable_q} :
    hit_ssw ? saved_status_word :
    hit_dfs ? data_fault_status :
    hit_addr ? fault_inst_addr :
    hit_kind ? {30'h0, last_kind_q} : fault_classifier_pkg::word_zero;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      bus_q <= fault_classifier_pkg::bus_idle;
      avs_waitrequest <= 1'b1;
      avs_readdata <= fault_classifier_pkg::word_zero;
    end else begin
      bus_q <= bus_d;
      avs_waitrequest <= (bus_d != fault_classifier_pkg::bus_answer);
      if (avs_read && bus_q == fault_classifier_pkg::bus_idle) begin
        avs_readdata <= rd_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // writable registers
  // ----------------------------------------------------------------
  // partial writes merge by lane; single-bit fields follow lane 0
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hw_config_q <= fault_classifier_pkg::hw_config_reset;
      ext_enable_q <= fault_classifier_pkg::control_ext_reset;
      ev_mask_q <= fault_classifier_pkg::ev_none;
    end else if (wr_commit) begin
      if (hit_config) begin
        hw_config_q <= (hw_config_q & ~lane_mask) | (avs_writedata & lane_mask);
      end
      if (hit_control && lanes[0]) begin
        ext_enable_q <= avs_writedata[fault_classifier_pkg::ctl_ext_enable_bit];
      end
      if (hit_mask && lanes[0]) begin
        ev_mask_q <= avs_writedata[fault_classifier_pkg::ev_width-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // sticky events and interrupt
  // ----------------------------------------------------------------
  // a new fault in the clearing cycle survives: set is applied after clear
  wire [fault_classifier_pkg::ev_width-1:0] ev_set = {sel_align, sel_data, sel_inst};
  wire [fault_classifier_pkg::ev_width-1:0] ev_clr =
    (wr_commit && hit_status && lanes[0]) ?
    avs_writedata[fault_classifier_pkg::ev_width-1:0] : fault_classifier_pkg::ev_none;

  always_comb begin
    ev_status_d = (ev_status_q & ~ev_clr) | ev_set;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ev_status_q <= fault_classifier_pkg::ev_none;
      irq <= 1'b0;
    end else begin
      ev_status_q <= ev_status_d;
      irq <= |(ev_status_d & ev_mask_q);
    end
  end

endmodule

// ### dv/fault_class_chk.sv
// timing checks on the fault classifier ports.
// assumes one clock, async active-low reset.
`timescale 1ns/1ns

module fault_class_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // access side
  input wire logic access_valid,
  input wire logic access_is_fetch,
  input wire logic [31:0] access_inst_addr,
  input wire logic instruction_translation_enable,
  input wire logic data_translation_enable,
  input wire logic block_hit,
  input wire logic page_found,
  input wire logic direct_store_select,
  input wire logic operand_misaligned,
  // fault report
  input wire logic fault_valid,
  input wire logic instruction_storage_fault,
  input wire logic data_storage_fault,
  input wire logic alignment_fault,
  input wire logic [31:0] saved_status_word,
  input wire logic [31:0] data_fault_status,
  input wire logic [31:0] fault_inst_addr,
  // bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire [2:0] kinds = {alignment_fault, data_storage_fault, instruction_storage_fault};
  wire dacc = access_valid && !access_is_fetch && data_translation_enable;
  // direct-store segments have no page lookup, so no page fault there
  wire miss = !block_hit && !page_found && !direct_store_select;

  property p_one_kind; fault_valid |-> $onehot(kinds); endproperty
  a_one_kind: assert property (p_one_kind) else $error("fault kinds not one-hot");
  property p_no_stray; !fault_valid |-> kinds == 3'h0; endproperty
  a_no_stray: assert property (p_no_stray) else $error("kind without fault");
  property p_cause; fault_valid |-> $past(access_valid); endproperty
  a_cause: assert property (p_cause) else $error("fault without access");
  property p_fetch_kind; fault_valid |-> instruction_storage_fault == $past(access_is_fetch);
  endproperty
  a_fetch_kind: assert property (p_fetch_kind) else $error("fetch kind wrong");
  property p_addr; fault_valid |-> fault_inst_addr == $past(access_inst_addr); endproperty
  a_addr: assert property (p_addr) else $error("fault address wrong");
  property p_fetch_miss;
    access_valid && access_is_fetch && instruction_translation_enable && miss |=>
      instruction_storage_fault && saved_status_word[fault_classifier_pkg::ssw_page_fault_bit];
  endproperty
  a_fetch_miss: assert property (p_fetch_miss) else $error("fetch miss lost");
  property p_data_miss;
    dacc && miss |=> alignment_fault ||
      (data_storage_fault && data_fault_status[fault_classifier_pkg::dfs_page_fault_bit]);
  endproperty
  a_data_miss: assert property (p_data_miss) else $error("data miss lost");
  property p_dt_off;
    access_valid && !access_is_fetch && !data_translation_enable |=> !data_storage_fault;
  endproperty
  a_dt_off: assert property (p_dt_off) else $error("data fault untranslated");
  property p_misalign; dacc && operand_misaligned |=> alignment_fault; endproperty
  a_misalign: assert property (p_misalign) else $error("misalign missed");
  property p_bus_ans; $rose(avs_read || avs_write) |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_bus_ans: assert property (p_bus_ans) else $error("bus answer timing wrong");

  c_inst: cover property (fault_valid && instruction_storage_fault);
  c_data: cover property (fault_valid && data_storage_fault);
  c_align: cover property (fault_valid && alignment_fault);
endmodule

bind mmu_fault_classifier fault_class_chk u_fault_class_chk (.*);

// ### dv/core_access_model.sv
// stand-in for the core's fetch and load/store logic.
// assumes the bench pulses go for one cycle with stable attributes.
`timescale 1ns/1ns

module core_access_model (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // bench request
  input wire logic go,
  input wire logic [20:0] attr,
  input wire logic [31:0] addr,
  // toward the classifier
  output logic access_valid,
  output logic [20:0] acc,
  output logic [31:0] access_inst_addr
);
  // lines toggle outside the valid cycle so unqualified use shows up
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      access_valid <= 1'b0;
      acc <= 21'h0;
      access_inst_addr <= 32'h0;
    end else begin
      access_valid <= go;
      acc <= go ? attr : ~acc;
      access_inst_addr <= go ? addr : ~access_inst_addr;
    end
  end
endmodule

// ### dv/mmu_fault_classifier_tb.sv
// self-checking bench for the fault classifier.
// assumes the access model and checker bind are compiled alongside.
`timescale 1ns/1ns

module mmu_fault_classifier_tb;
  localparam logic [20:0] it = 21'h1, dt = 21'h2, le = 21'h4, bh = 21'h8, pf = 21'h10,
    bpv = 21'h20, ppv = 21'h40, nx = 21'h80, ds = 21'h100, bg = 21'h200, pg = 21'h400,
    wt = 21'h800, ci = 21'h1000, cz = 21'h2000, rs = 21'h4000, ec = 21'h8000,
    fp = 21'h10000, ms = 21'h20000, mis = 21'h40000, dse = 21'h80000, fe = 21'h100000;
  // documented bit n sits at index 31-n
  localparam logic [31:0] pg_b = 32'h4000_0000, ex_b = 32'h1000_0000, pr_b = 32'h0800_0000,
    rs_b = 32'h0400_0000, er_b = 32'h8000_0000, ec_b = 32'h0010_0000;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic go = 1'b0;
  logic [20:0] attr = 21'h0;
  logic [31:0] addr = 32'h0;
  logic [5:0] avs_address = 6'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic access_valid, fault_valid, instruction_storage_fault, data_storage_fault;
  logic alignment_fault, avs_waitrequest, irq;
  logic [20:0] acc;
  logic [31:0] access_inst_addr, saved_status_word, data_fault_status, fault_inst_addr;
  logic [31:0] avs_readdata, rdata;
  int error_cnt = 0;
  int checks_done = 0;

  always #5 mclk = ~mclk;

  core_access_model u_core_access_model (.mclk, .reset_n, .go, .attr, .addr,
    .access_valid, .acc, .access_inst_addr);
  mmu_fault_classifier u_mmu_fault_classifier (
    .mclk, .reset_n, .access_valid, .access_is_fetch(acc[20]), .access_inst_addr,
    .instruction_translation_enable(acc[0]), .data_translation_enable(acc[1]),
    .little_endian_mode(acc[2]), .block_hit(acc[3]), .page_found(acc[4]),
    .block_protect_violation(acc[5]), .page_protect_violation(acc[6]),
    .no_execute_bit(acc[7]), .direct_store_select(acc[8]), .block_guarded_bit(acc[9]),
    .page_guarded_bit(acc[10]), .write_through(acc[11]), .cache_inhibited(acc[12]),
    .op_cache_zero(acc[13]), .op_reservation(acc[14]), .op_ext_control(acc[15]),
    .op_float(acc[16]), .op_multi_string(acc[17]), .operand_misaligned(acc[18]),
    .direct_store_error(acc[19]), .fault_valid, .instruction_storage_fault,
    .data_storage_fault, .alignment_fault, .saved_status_word, .data_fault_status,
    .fault_inst_addr, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq);

  // ----
  // shared tasks
  // ----
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task bus(input logic we, input logic [5:0] a, input logic [31:0] wd, input logic [3:0] be);
    avs_address <= a;
    avs_writedata <= wd;
    avs_byteenable <= be;
    avs_read <= !we;
    avs_write <= we;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask

  // k is {align,data,inst}; st the status word of that kind
  task acc_chk(input logic [20:0] at, input logic [2:0] k, input logic [31:0] st);
    attr <= at;
    addr <= addr + 32'h0000_0104;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
    check("kind", {29'h0, k}, {29'h0, alignment_fault, data_storage_fault,
      instruction_storage_fault});
    check("fault_valid", {31'h0, |k}, {31'h0, fault_valid});
    if (k[0]) check("saved status", st, saved_status_word);
    if (k[1]) check("data status", st, data_fault_status);
    if (k[1]) check("saved status idle", 32'h0, saved_status_word);
    if (k[0]) check("data status idle", 32'h0, data_fault_status);
    if (k[2]) check("align status", 32'h0, saved_status_word | data_fault_status);
    if (|k) check("fault addr", addr, fault_inst_addr);
    @(posedge mclk);
  endtask

  task irq_is(input logic v);
    @(negedge mclk);
    check("irq", {31'h0, v}, {31'h0, irq});
    @(posedge mclk);
  endtask

  // ----
  // scenarios
  // ----
  task t_regs;
    bus(0, fault_classifier_pkg::reg_hw_config, 0, 4'hf);
    check("config reset", fault_classifier_pkg::hw_config_reset, rdata);
    bus(0, fault_classifier_pkg::reg_control, 0, 4'hf);
    check("control reset", 32'h0, rdata);
    bus(1, 6'h20, 32'hffff_ffff, 4'hf);
    bus(0, 6'h20, 0, 4'hf);
    check("unmapped", 32'h0, rdata);
    $display("test regs done");
  endtask

  task t_fetch;
    acc_chk(fe | it, 3'h1, pg_b);
    acc_chk(fe | it | nx, 3'h1, pg_b | ex_b);
    acc_chk(fe | it | bh | bpv, 3'h1, pr_b);
    acc_chk(fe | it | pf | ppv, 3'h1, pr_b);
    acc_chk(fe | it | pf | nx, 3'h1, ex_b);
    acc_chk(fe | it | pf | ds, 3'h1, ex_b);
    acc_chk(fe | it | bh | bg, 3'h1, ex_b);
    acc_chk(fe | it | pf | pg, 3'h1, ex_b);
    acc_chk(fe | it | bh | pg, 3'h0, 0);
    acc_chk(fe | pf | nx | pg, 3'h0, 0);
    $display("test fetch done");
  endtask

  task t_data;
    acc_chk(dt, 3'h2, pg_b);
    acc_chk(dt | bh | bpv, 3'h2, pr_b);
    acc_chk(dt | pf | ppv, 3'h2, pr_b);
    acc_chk(dt | pf | wt | rs, 3'h2, rs_b);
    acc_chk(dt | bh | wt | rs, 3'h2, rs_b);
    acc_chk(dt | pf | ds | rs, 3'h2, rs_b);
    acc_chk(dt | pf | ds | dse, 3'h2, er_b);
    acc_chk(dt | pf | ec, 3'h2, ec_b);
    bus(1, fault_classifier_pkg::reg_control, 32'h1, 4'hf);
    acc_chk(dt | pf | ec, 3'h0, 0);
    acc_chk(dt | pf | ds | ec, 3'h2, rs_b);
    acc_chk(ds | rs | dse | wt | ppv, 3'h0, 0);
    $display("test data done");
  endtask

  task t_align;
    acc_chk(dt | pf | cz | wt, 3'h4, 0);
    acc_chk(dt | bh | cz | ci, 3'h4, 0);
    acc_chk(dt | pf | ds | fp, 3'h4, 0);
    acc_chk(le | ms, 3'h4, 0);
    acc_chk(dt | pf | ms, 3'h0, 0);
    acc_chk(dt | pf | mis, 3'h4, 0);
    acc_chk(pf | mis | fp | ds, 3'h0, 0);
    acc_chk(dt | mis | wt | rs, 3'h4, 0);
    bus(1, fault_classifier_pkg::reg_hw_config, 32'h0000_3000, 4'hd);
    acc_chk(cz, 3'h0, 0);
    bus(1, fault_classifier_pkg::reg_hw_config, 32'h0000_3000, 4'hf);
    acc_chk(cz, 3'h4, 0);
    bus(1, fault_classifier_pkg::reg_hw_config, 32'h0000_1000, 4'hf);
    acc_chk(cz, 3'h0, 0);
    $display("test align done");
  endtask

  task t_irq;
    bus(0, fault_classifier_pkg::reg_event_status, 0, 4'hf);
    check("status", 32'h7, rdata);
    irq_is(1'b0);
    bus(1, fault_classifier_pkg::reg_event_mask, 32'h2, 4'hf);
    irq_is(1'b1);
    bus(1, fault_classifier_pkg::reg_event_status, 32'h2, 4'hf);
    irq_is(1'b0);
    bus(0, fault_classifier_pkg::reg_event_status, 0, 4'hf);
    check("status after clear", 32'h5, rdata);
    acc_chk(dt, 3'h2, pg_b);
    irq_is(1'b1);
    bus(0, fault_classifier_pkg::reg_fault_kind, 0, 4'hf);
    check("last kind", 32'h2, rdata);
    bus(1, fault_classifier_pkg::reg_event_status, 32'h7, 4'hf);
    irq_is(1'b0);
    $display("test irq done");
  endtask

  task print_verdict;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_fetch();
    t_data();
    t_align();
    t_irq();
    print_verdict();
  end

  // run needs well under 2000 cycles
  initial begin
    #200000;
    error_cnt++;
    print_verdict();
  end
endmodule
